// >>> src/serial_config_pkg.sv
// Shared constants, state types and decode helpers for the config serial port
package serial_config_pkg;

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLK_PERIOD_NS = 25;
    localparam int SCLK_HALF_NS  = 250;    // Far below the 100 MHz serial limit
    localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] DIV_LAST = 4'(SCLK_HALF_CYC - 1);

    // ----------------------------------------
    // Serial framing
    // ----------------------------------------
    localparam logic [3:0] INSTR_LAST = 4'hf;
    localparam logic [3:0] BYTE_LAST  = 4'h7;
    localparam logic [5:0] INSTR_BITS = 6'h10;
    localparam int         RW_BIT     = 15;

    // ----------------------------------------
    // Device register map
    // ----------------------------------------
    localparam int          REG_COUNT = 16;
    localparam logic [14:0] CFG_ADDR  = 15'h0000;
    localparam logic [14:0] LOAD_ADDR = 15'h0001;
    localparam logic [14:0] REG_LAST  = 15'h000f;
    localparam logic [3:0]  TW_LO_IDX = 4'h2;
    localparam logic [3:0]  TW_HI_IDX = 4'h3;
    localparam int          LOAD_BIT  = 0;
    localparam logic [7:0]  CFG_RESET = 8'h00;
    localparam logic [15:0] TW_RESET  = 16'h0000;
    localparam int CFG_LSB_HI = 6;
    localparam int CFG_INC_HI = 5;
    localparam int CFG_SDO_HI = 4;
    localparam int CFG_SDO_LO = 3;
    localparam int CFG_INC_LO = 2;
    localparam int CFG_LSB_LO = 1;

    // ----------------------------------------
    // Controller register map (byte offsets)
    // ----------------------------------------
    localparam logic [4:0] OFS_CMD    = 5'h00;
    localparam logic [4:0] OFS_MODE   = 5'h04;
    localparam logic [4:0] OFS_WDATA  = 5'h08;
    localparam logic [4:0] OFS_RDATA  = 5'h0c;
    localparam logic [4:0] OFS_STATUS = 5'h10;
    localparam int CMD_READ  = 15;
    localparam int CMD_BYTES = 16;
    localparam int CMD_START = 18;
    localparam int MODE_LSB  = 0;
    localparam int MODE_4W   = 1;
    localparam int STAT_BUSY = 0;
    localparam int STAT_DONE = 1;

    typedef enum logic [0:0] {PH_INSTR = 1'b0, PH_DATA = 1'b1} phase_t;
    typedef enum logic [1:0] {H_IDLE = 2'b00, H_SHIFT = 2'b01, H_GAP = 2'b10} host_state_t;

    // Mirrored config bits: either copy selects the option
    function automatic logic cfgLsb(input logic [7:0] c);
        return c[CFG_LSB_HI] | c[CFG_LSB_LO];
    endfunction
    function automatic logic cfgInc(input logic [7:0] c);
        return c[CFG_INC_HI] | c[CFG_INC_LO];
    endfunction
    function automatic logic cfgFourWire(input logic [7:0] c);
        return c[CFG_SDO_HI] | c[CFG_SDO_LO];
    endfunction

endpackage

// >>> src/serial_config_if.sv
// Serial pins between the controller end and the device end
`timescale 1ns/100ps
`default_nettype none
interface serial_config_if;
    logic sclk;
    logic csN;
    logic sdioHostOut;
    logic sdioHostOeN;
    logic sdioDevOut;
    logic sdioDevOeN;
    logic separateSerialOut;
    logic sdio;

    // Resolved shared data wire, pulled high when nobody drives
    assign sdio = !sdioHostOeN ? sdioHostOut : (!sdioDevOeN ? sdioDevOut : 1'b1);

    modport device (input sclk, csN, sdio, output sdioDevOut, sdioDevOeN, separateSerialOut);
    modport host (output sclk, csN, sdioHostOut, sdioHostOeN, input sdio, separateSerialOut);
endinterface
`default_nettype wire

// >>> src/serial_config_device.sv
// Device end of the configuration serial port with its register file
`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// - First sixteen rising edges form instruction
// - Chip select high restarts instruction phase
// - Each data byte takes eight clocks
// - Writes land per byte; tuning word on load
// - Instruction bit 15 set means read
// - Low fifteen bits give start address
// - Address steps up or down per byte
// - Controller holds select for extra bytes
// - Serial clock never above 100 MHz
// - Sample on rising, launch on falling
// - Data pin released while select high
// - Config bits pick bit order, MSB default
// - Bit sequence mirrors fully in LSB mode
// - Config bits choose separate output pin
// - Config writes use first nibble only
module serial_config_device
    import serial_config_pkg::*;
(
    input  wire logic          clock,
    input  wire logic          sys_rst,
    serial_config_if.device    link,
    output logic [7:0]         configByte,
    output logic [15:0]        tuningWord,
    output logic               writeStrobe,
    output logic [14:0]        writeAddr,
    output logic [7:0]         writeData
);

    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        logic [2:0]                 sclkSync;
        logic [2:0]                 csSync;
        logic [2:0]                 sdioSync;
        logic                       sclkLvl;
        logic                       csLvl;
        phase_t                     phase;
        logic [3:0]                 bitCnt;
        logic [15:0]                shift;
        logic [14:0]                addr;
        logic                       isRead;
        logic [7:0]                 outByte;
        logic                       sdioOut;
        logic                       sdioOeN;
        logic                       sdoOut;
        logic [7:0]                 cfg;
        logic [REG_COUNT-1:0][7:0]  regs;
        logic [15:0]                tuning;
        logic                       wrStrobe;
        logic [14:0]                wrAddr;
        logic [7:0]                 wrData;
    } dev_state_t;

    localparam dev_state_t DEV_RESET = '{
        csSync: 3'h7, csLvl: 1'b1, sdioOeN: 1'b1, cfg: CFG_RESET,
        tuning: TW_RESET, phase: PH_INSTR, default: '0};

    dev_state_t stQ;
    dev_state_t stD;

    // Readback of one register; unmapped addresses read as zero
    function automatic logic [7:0] regRead(input dev_state_t s, input logic [14:0] a);
        logic [7:0] v;
        v = 8'h00;
        if (a == CFG_ADDR) begin
            v = s.cfg;
        end else if (a <= REG_LAST) begin
            v = s.regs[a[3:0]];
        end
        return v;
    endfunction

    logic       rise;
    logic       fall;
    logic       inBit;
    logic       lsb;
    logic       outBit;
    logic [7:0] newByte;
    logic [3:0] nib;

    // ----------------------------------------
    // Next-state logic
    // ----------------------------------------
    always_comb begin
        stD = stQ;
        stD.wrStrobe = 1'b0;
        rise = 1'b0;
        fall = 1'b0;
        outBit = 1'b0;
        newByte = 8'h00;
        nib = 4'h0;
        lsb = cfgLsb(stQ.cfg);
        inBit = stQ.sdioSync[2];

        // Three-stage pin synchronisers; sclk and select levels count once stages two and three agree, data is taken from stage three
        stD.sclkSync = {stQ.sclkSync[1:0], link.sclk};
        stD.csSync = {stQ.csSync[1:0], link.csN};
        stD.sdioSync = {stQ.sdioSync[1:0], link.sdio};
        if (stQ.sclkSync[1] == stQ.sclkSync[2]) begin
            stD.sclkLvl = stQ.sclkSync[2];
        end
        if (stQ.csSync[1] == stQ.csSync[2]) begin
            stD.csLvl = stQ.csSync[2];
        end
        rise = !stQ.sclkLvl && stD.sclkLvl;
        fall = stQ.sclkLvl && !stD.sclkLvl;

        if (stD.csLvl) begin
            // Deselected: drop any transfer, release the shared data pin and drive the separate output low
            stD.phase = PH_INSTR;
            stD.bitCnt = 4'h0;
            stD.isRead = 1'b0;
            stD.sdioOeN = 1'b1;
            stD.sdoOut = 1'b0;
        end else if (rise) begin
            // Input bits are taken only on rising serial edges
            case (stQ.phase)
                PH_INSTR: begin
                    stD.shift = lsb ? {inBit, stQ.shift[15:1]}
                                    : {stQ.shift[14:0], inBit};
                    stD.bitCnt = stQ.bitCnt + 4'h1;
                    if (stQ.bitCnt == INSTR_LAST) begin
                        stD.phase = PH_DATA;
                        stD.bitCnt = 4'h0;
                        stD.isRead = stD.shift[RW_BIT];
                        stD.addr = stD.shift[14:0];
                        stD.outByte = regRead(stQ, stD.shift[14:0]);
                    end
                end
                PH_DATA: begin
                    newByte = lsb ? {inBit, stQ.shift[7:1]}
                                  : {stQ.shift[6:0], inBit};
                    stD.shift = {8'h00, newByte};
                    stD.bitCnt = stQ.bitCnt + 4'h1;
                    if (stQ.bitCnt == BYTE_LAST) begin
                        stD.bitCnt = 4'h0;
                        if (!stQ.isRead) begin
                            // Each byte lands the moment its last bit arrives
                            stD.wrStrobe = 1'b1;
                            stD.wrAddr = stQ.addr;
                            stD.wrData = newByte;
                            if (stQ.addr == CFG_ADDR) begin
                                // Only the first nibble on the wire is evaluated
                                nib = lsb ? newByte[3:0]
                                          : {newByte[4], newByte[5], newByte[6], newByte[7]};
                                stD.cfg = {nib[0], nib[1], nib[2], nib[3],
                                           nib[3], nib[2], nib[1], nib[0]};
                                if (nib[0]) begin
                                    // Soft reset: registers back to defaults, bit clears
                                    stD.cfg = CFG_RESET;
                                    stD.regs = '0;
                                    stD.tuning = TW_RESET;
                                end
                            end else if (stQ.addr <= REG_LAST) begin
                                stD.regs[stQ.addr[3:0]] = newByte;
                                // Tuning word shadows only reach the output on a load request
                                if (stQ.addr == LOAD_ADDR && newByte[LOAD_BIT]) begin
                                    stD.tuning = {stQ.regs[TW_HI_IDX],
                                                  stQ.regs[TW_LO_IDX]};
                                    stD.regs[LOAD_ADDR[3:0]][LOAD_BIT] = 1'b0;
                                end
                            end
                        end
                        // Multibyte access walks the address one step per byte
                        stD.addr = cfgInc(stQ.cfg) ? stQ.addr + 15'h0001
                                                   : stQ.addr - 15'h0001;
                        stD.outByte = regRead(stQ, stD.addr);
                    end
                end
                default: begin
                    stD.phase = PH_INSTR;
                end
            endcase
        end else if (fall && stQ.phase == PH_DATA && stQ.isRead) begin
            // Read data launches on falling edges, first bit after the instruction
            outBit = lsb ? stQ.outByte[0] : stQ.outByte[7];
            stD.outByte = lsb ? {1'b0, stQ.outByte[7:1]} : {stQ.outByte[6:0], 1'b0};
            if (cfgFourWire(stQ.cfg)) begin
                stD.sdoOut = outBit;
            end else begin
                // Turn the shared pin only now, once the controller has let go
                stD.sdioOut = outBit;
                stD.sdioOeN = 1'b0;
            end
        end
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            stQ <= DEV_RESET;
        end else begin
            stQ <= stD;
        end
    end

    // ----------------------------------------
    // Outputs, all straight from the state register
    // ----------------------------------------
    assign link.sdioDevOut = stQ.sdioOut;
    assign link.sdioDevOeN = stQ.sdioOeN;
    assign link.separateSerialOut = stQ.sdoOut;
    assign configByte = stQ.cfg;
    assign tuningWord = stQ.tuning;
    assign writeStrobe = stQ.wrStrobe;
    assign writeAddr = stQ.wrAddr;
    assign writeData = stQ.wrData;

endmodule
`default_nettype wire

// >>> src/serial_config_host.sv
// Controller end: Avalon-MM register slave driving the serial config link
`timescale 1ns/100ps
`default_nettype none
module serial_config_host
    import serial_config_pkg::*;
(
    input  wire logic          clock,
    input  wire logic          sys_rst,
    input  wire logic [4:0]    address,
    input  wire logic          read,
    input  wire logic          write,
    input  wire logic [31:0]   writedata,
    input  wire logic [3:0]    byteenable,
    output logic [31:0]        readdata,
    output logic               waitrequest,
    serial_config_if.host      link
);

    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        logic         waitReq;
        logic [31:0]  readData;
        logic [14:0]  cmdAddr;
        logic         cmdRead;
        logic [1:0]   cmdBytes;
        logic         lsbFirst;
        logic         fourWire;
        logic [31:0]  wdata;
        logic [31:0]  rdata;
        logic [31:0]  rx;
        logic         done;
        host_state_t  state;
        logic [3:0]   divCnt;
        logic [5:0]   bitCnt;
        logic         sclk;
        logic         csN;
        logic         sdioOut;
        logic         sdioOeN;
        logic [2:0]   sdioSync;
        logic [2:0]   sdoSync;
        logic         sdioLvl;
        logic         sdoLvl;
    } host_state_s_t;

    localparam host_state_s_t HOST_RESET = '{
        waitReq: 1'b1, csN: 1'b1, sdioOeN: 1'b1, state: H_IDLE, default: '0};

    host_state_s_t stQ;
    host_state_s_t stD;

    // Bit position inside the data word for data bit d on the wire
    function automatic logic [4:0] dataIdx(input logic lsbMode, input logic [5:0] d);
        return {d[4:3], lsbMode ? d[2:0] : 3'h7 - d[2:0]};
    endfunction

    // Byte-lane merge of a bus write into an existing word
    function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] w,
                                          input logic [3:0] be);
        logic [31:0] r;
        r = o;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = w[i*8 +: 8];
            end
        end
        return r;
    endfunction

    logic        req;
    logic        busy;
    logic        startReq;
    logic        tick;
    logic        inBit;
    logic [5:0]  dBit;
    logic [5:0]  totalBits;
    logic [15:0] instr;
    logic [31:0] cmdWord;
    logic [31:0] m;

    // ----------------------------------------
    // Next-state logic: bus slave, then serial engine
    // ----------------------------------------
    always_comb begin
        stD = stQ;
        req = read || write;
        busy = stQ.state != H_IDLE;
        startReq = 1'b0;
        m = 32'h0;
        cmdWord = {14'h0, stQ.cmdBytes, stQ.cmdRead, stQ.cmdAddr};
        instr = {stQ.cmdRead, stQ.cmdAddr};
        totalBits = 6'h18 + {1'b0, stQ.cmdBytes, 3'h0};
        dBit = stQ.bitCnt - INSTR_BITS;
        tick = stQ.divCnt == DIV_LAST;

        stD.sdioSync = {stQ.sdioSync[1:0], link.sdio};
        stD.sdoSync = {stQ.sdoSync[1:0], link.separateSerialOut};
        if (stQ.sdioSync[1] == stQ.sdioSync[2]) begin
            stD.sdioLvl = stQ.sdioSync[2];
        end
        if (stQ.sdoSync[1] == stQ.sdoSync[2]) begin
            stD.sdoLvl = stQ.sdoSync[2];
        end
        inBit = stQ.fourWire ? stQ.sdoLvl : stQ.sdioLvl;

        // One wait cycle; read data is latched so it stands when waitrequest drops
        stD.waitReq = !(req && stQ.waitReq);
        if (read && stQ.waitReq) begin
            if (address == OFS_CMD) begin
                stD.readData = cmdWord;
            end else if (address == OFS_MODE) begin
                stD.readData = {30'h0, stQ.fourWire, stQ.lsbFirst};
            end else if (address == OFS_WDATA) begin
                stD.readData = stQ.wdata;
            end else if (address == OFS_RDATA) begin
                stD.readData = stQ.rdata;
            end else if (address == OFS_STATUS) begin
                stD.readData = {30'h0, stQ.done, busy};
            end else begin
                stD.readData = 32'h0;
            end
        end
        // Writes act at the edge that completes the handshake; setup ignored while busy
        if (write && !stQ.waitReq) begin
            if (address == OFS_CMD && !busy) begin
                m = merge(cmdWord, writedata, byteenable);
                stD.cmdAddr = m[14:0];
                stD.cmdRead = m[CMD_READ];
                stD.cmdBytes = m[CMD_BYTES +: 2];
                startReq = byteenable[2] && writedata[CMD_START];
            end else if (address == OFS_MODE && !busy) begin
                m = merge({30'h0, stQ.fourWire, stQ.lsbFirst}, writedata, byteenable);
                stD.lsbFirst = m[MODE_LSB];
                stD.fourWire = m[MODE_4W];
            end else if (address == OFS_WDATA && !busy) begin
                stD.wdata = merge(stQ.wdata, writedata, byteenable);
            end else if (address == OFS_STATUS) begin
                if (byteenable[0] && writedata[STAT_DONE]) begin
                    stD.done = 1'b0;
                end
            end
        end

        // Serial engine; sclk half period from the divider keeps well under 100 MHz
        case (stQ.state)
            H_IDLE: begin
                if (startReq) begin
                    stD.state = H_SHIFT;
                    stD.csN = 1'b0;
                    stD.sdioOeN = 1'b0;
                    stD.sdioOut = stD.lsbFirst ? stD.cmdAddr[0] : stD.cmdRead;
                    stD.divCnt = 4'h0;
                    stD.bitCnt = 6'h0;
                    stD.rx = 32'h0;
                end
            end
            H_SHIFT: begin
                stD.divCnt = tick ? 4'h0 : stQ.divCnt + 4'h1;
                if (tick && !stQ.sclk) begin
                    stD.sclk = 1'b1;
                    if (stQ.cmdRead && stQ.bitCnt >= INSTR_BITS) begin
                        stD.rx[dataIdx(stQ.lsbFirst, dBit)] = inBit;
                    end
                    stD.bitCnt = stQ.bitCnt + 6'h1;
                end else if (tick) begin
                    stD.sclk = 1'b0;
                    if (stQ.bitCnt == totalBits) begin
                        // Select held low over every requested byte slot
                        stD.csN = 1'b1;
                        stD.sdioOeN = 1'b1;
                        stD.state = H_GAP;
                        stD.rdata = stQ.rx;
                    end else if (stQ.cmdRead && stQ.bitCnt >= INSTR_BITS) begin
                        stD.sdioOeN = !stQ.fourWire;
                        stD.sdioOut = 1'b0;
                    end else if (stQ.bitCnt < INSTR_BITS) begin
                        stD.sdioOut = instr[stQ.lsbFirst ? stQ.bitCnt[3:0]
                                                         : 4'hf - stQ.bitCnt[3:0]];
                    end else begin
                        stD.sdioOut = stQ.wdata[dataIdx(stQ.lsbFirst, dBit)];
                    end
                end
            end
            H_GAP: begin
                // Deselect time long enough for the device to see select high
                stD.divCnt = tick ? 4'h0 : stQ.divCnt + 4'h1;
                if (tick) begin
                    stD.state = H_IDLE;
                    stD.done = 1'b1;
                end
            end
            default: begin
                stD.state = H_IDLE;
            end
        endcase
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            stQ <= HOST_RESET;
        end else begin
            stQ <= stD;
        end
    end

    assign readdata = stQ.readData;
    assign waitrequest = stQ.waitReq;
    assign link.sclk = stQ.sclk;
    assign link.csN = stQ.csN;
    assign link.sdioHostOut = stQ.sdioOut;
    assign link.sdioHostOeN = stQ.sdioOeN;

endmodule
`default_nettype wire

// >>> test/serial_config_asserts.sv
// Checker for the serial pins between the two ends
`timescale 1ns/100ps
`default_nettype none
module serial_config_asserts (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic sclk,
    input wire logic csN,
    input wire logic sdioHostOut,
    input wire logic sdioHostOeN,
    input wire logic sdioDevOut,
    input wire logic sdioDevOeN,
    input wire logic separateSerialOut
);
    // ----
    // Rising sclk edges seen in the current frame
    // ----
    logic [7:0] riseCount_q;
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) riseCount_q <= 8'h00;
        else riseCount_q <= csN ? 8'h00 : riseCount_q + {7'h00, $rose(sclk)};
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    // Frame: sixteen instruction edges then whole bytes only
    a_frame_length: assert property ($rose(csN) |->
            riseCount_q >= 8'h18 && riseCount_q[2:0] == 3'h0)
        else $error("frame length wrong");
    a_pin_release: assert property (csN [*6] |-> sdioDevOeN)
        else $error("data pin held while deselected");
    a_out_idle: assert property (csN [*6] |-> !separateSerialOut)
        else $error("separate output busy while deselected");
    a_no_clash: assert property (!(!sdioHostOeN && !sdioDevOeN))
        else $error("both ends drive the data pin");
    a_sclk_idle: assert property (csN |-> !sclk)
        else $error("serial clock runs outside a frame");
    a_half_period: assert property ($rose(sclk) |-> sclk [*8])
        else $error("serial clock high too short");
    a_host_hold: assert property (!sdioHostOeN && $rose(sclk) |-> $stable(sdioHostOut))
        else $error("host data moved at rising edge");
    // Device launches only while sclk is low, so the rising edge sees settled data
    a_dev_launch: assert property (!sdioDevOeN && !$past(sdioDevOeN) &&
            $changed(sdioDevOut) |-> !sclk)
        else $error("device data moved while clock high");
    a_sep_launch: assert property ($changed(separateSerialOut) |-> !sclk)
        else $error("separate output moved while clock high");
    a_turn_around: assert property ($fell(sdioDevOeN) |-> !sclk && !csN && sdioHostOeN)
        else $error("device took the pin too early");
    cover property (!sdioDevOeN);
    cover property ($rose(separateSerialOut));
    cover property ($rose(csN) && riseCount_q == 8'h30);
endmodule
`default_nettype wire

// >>> test/testbench.sv
// Bench joining both ends; drives the controller over its register bus
`timescale 1ns/100ps
`default_nettype none
module testbench import serial_config_pkg::*; ();
    logic        clock = 1'b0;
    logic        sys_rst = 1'b1;
    logic        read = 1'b0;
    logic        write = 1'b0;
    logic        chkRd = 1'b0;
    logic [4:0]  address = 5'h00;
    logic [31:0] writedata = 32'h0;
    logic [31:0] readdata, got, d;
    logic        waitrequest, writeStrobe;
    logic [7:0]  configByte, writeData;
    logic [7:0]  cfg = 8'h00;
    logic [14:0] writeAddr;
    logic [15:0] tuningWord;
    logic [31:0] expR [$];
    logic [22:0] expW [$];
    logic [7:0]  modes [4] = '{8'h00, 8'h3c, 8'h66, 8'h5a};
    int          num_errors = 0, n_checks = 0, seed = 15;
    serial_config_if link ();
    serial_config_host serial_config_host_inst (.clock(clock), .sys_rst(sys_rst),
        .address(address), .read(read), .write(write), .writedata(writedata),
        .byteenable(4'hf), .readdata(readdata), .waitrequest(waitrequest), .link(link.host));
    serial_config_device serial_config_device_inst (.clock(clock), .sys_rst(sys_rst),
        .link(link.device), .configByte(configByte), .tuningWord(tuningWord),
        .writeStrobe(writeStrobe), .writeAddr(writeAddr), .writeData(writeData));
    serial_config_asserts serial_config_asserts_inst (.clock(clock), .sys_rst(sys_rst),
        .sclk(link.sclk), .csN(link.csN), .sdioHostOut(link.sdioHostOut),
        .sdioHostOeN(link.sdioHostOeN), .sdioDevOut(link.sdioDevOut),
        .sdioDevOeN(link.sdioDevOeN), .separateSerialOut(link.separateSerialOut));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask
    task automatic final_report();
        $display("checks %0d, mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // One bus cycle; for a checked read, v is the expected word
    task automatic bus(input logic rd, input logic [4:0] a, input logic [31:0] v, input logic c);
        @(posedge clock);
        read <= rd;
        write <= !rd;
        address <= a;
        writedata <= v;
        chkRd <= c;
        if (c) expR.push_back(v);
        do @(posedge clock); while (waitrequest !== 1'b0);
        got = readdata;
        read <= 1'b0;
        write <= 1'b0;
        chkRd <= 1'b0;
    endtask
    // Whole serial transfer; writes note each landed byte with its stepped address
    task automatic xfer(input logic rd, input logic [14:0] a, input logic [1:0] n,
                        input logic [31:0] v);
        for (int i = 0; i <= n; i++)
            if (!rd) expW.push_back({cfg[5] ? a + 15'(i) : a - 15'(i), v[8*i+:8]});
        bus(1'b0, OFS_WDATA, v, 1'b0);
        bus(1'b0, OFS_CMD, {13'h0, 1'b1, n, rd, a}, 1'b0);
        got = 32'h0;
        repeat (1000) if (got[STAT_DONE] !== 1'b1) bus(1'b1, OFS_STATUS, 32'h0, 1'b0);
        check({31'h0, got[STAT_DONE]}, 32'h1);
        bus(1'b0, OFS_STATUS, 32'h2, 1'b0);
    endtask
    // Result watcher: compares each checked read and each landed byte with the oldest note
    always @(posedge clock) begin
        if (read && !waitrequest && chkRd) check(readdata, expR.pop_front());
        if (writeStrobe === 1'b1 && expW.size() > 0)
            check({9'h0, writeAddr, writeData}, 32'(expW.pop_front()));
    end
    initial begin
        forever #12.5 clock = ~clock;
    end
    // Watchdog: the run needs some 12600 cycles
    initial begin
        repeat (90000) @(posedge clock);
        num_errors++;
        final_report();
    end
    initial begin
        repeat (10) @(posedge clock);
        sys_rst <= 1'b0;
        bus(1'b1, OFS_STATUS, 32'h0, 1'b1);
        bus(1'b1, 5'h14, 32'h0, 1'b1);
        check({24'h0, configByte}, 32'h0);
        // Tuning word moves only on the load request
        d = $random(seed);
        xfer(1'b0, 15'h3, 2'h1, d);
        check({16'h0, tuningWord}, 32'h0);
        xfer(1'b0, 15'h1, 2'h0, 32'h1);
        check({16'h0, tuningWord}, {16'h0, d[7:0], d[15:8]});
        $display("tuning word test done");
        // Each order, wiring and step mode; the ignored config nibble is corrupted
        foreach (modes[i]) begin
            xfer(1'b0, 15'h0, 2'h0, {24'h0, cfg[6] ? ~modes[i][7:4] : modes[i][7:4],
                cfg[6] ? modes[i][3:0] : ~modes[i][3:0]});
            cfg = modes[i];
            check({24'h0, configByte}, {24'h0, cfg});
            bus(1'b0, OFS_MODE, {30'h0, cfg[4], cfg[6]}, 1'b0);
            d = $random(seed);
            xfer(1'b0, 15'h7, 2'h3, d);
            xfer(1'b1, 15'h7, 2'h3, 32'h0);
            bus(1'b1, OFS_RDATA, d, 1'b1);
            $display("mode %h test done", cfg);
        end
        // Soft reset in the first nibble clears config, registers and tuning word
        xfer(1'b0, 15'h0, 2'h0, 32'h81);
        cfg = 8'h00;
        check({8'h0, configByte, tuningWord}, 32'h0);
        bus(1'b0, OFS_MODE, 32'h0, 1'b0);
        xfer(1'b1, 15'h7, 2'h3, 32'h0);
        bus(1'b1, OFS_RDATA, 32'h0, 1'b1);
        $display("soft reset test done");
        final_report();
    end
endmodule
`default_nettype wire
